//--- common/pao_pkg.sv
// pao_pkg: shared constants for the port alternate function override block
// assumes: included before all rtl files of the block
package pao_pkg;
  // port width and spi pin positions on the second port
  localparam int PAO_PORT_W = 8;
  localparam int PAO_SCK_BIT = 7;
  localparam int PAO_MISO_BIT = 6;
  localparam int PAO_MOSI_BIT = 5;
  // reset values of the registered pad controls and synchronised pad levels
  localparam logic [7:0] PAO_RST_PULLUP = 8'h00;
  localparam logic [7:0] PAO_RST_DIR = 8'h00;
  localparam logic [7:0] PAO_RST_VALUE = 8'h00;
  localparam logic [7:0] PAO_RST_INEN = 8'hff;
  localparam logic [7:0] PAO_RST_DIN = 8'h00;
endpackage : pao_pkg

//--- rtl/pao_pad_ctrl.sv
// pao_pad_ctrl: per-pin override resolution for one 8-bit port
// assumes: override pairs come from logic on the same clock
`timescale 1ns/100ps
module pao_pad_ctrl (
  // port registers and globals
  input wire logic [7:0] dir_bits,
  input wire logic [7:0] port_bits,
  input wire logic global_pullup_disable,
  input wire logic sleep_active,
  // override pairs
  input wire logic [7:0] pullup_override_enable,
  input wire logic [7:0] pullup_override_value,
  input wire logic [7:0] direction_override_enable,
  input wire logic [7:0] direction_override_value,
  input wire logic [7:0] value_override_enable,
  input wire logic [7:0] value_override_value,
  input wire logic [7:0] input_enable_override_enable,
  input wire logic [7:0] input_enable_override_value,
  // resolved pad controls
  output logic [7:0] pull_en,
  output logic [7:0] dir,
  output logic [7:0] value,
  output logic [7:0] in_en
);
  import pao_pkg::*;

  // one mux set per pin
  genvar i;
  generate
    for (i = 0; i < PAO_PORT_W; i++) begin : g_pin
      assign pull_en[i] = pullup_override_enable[i] ? pullup_override_value[i]
                       : (~dir_bits[i] & port_bits[i] & ~global_pullup_disable);
      assign dir[i] = direction_override_enable[i] ? direction_override_value[i] : dir_bits[i];
      assign value[i] = value_override_enable[i] ? value_override_value[i] : port_bits[i];
      assign in_en[i] = input_enable_override_enable[i] ? input_enable_override_value[i]
                      : ~sleep_active;
    end
  endgenerate
endmodule // pao_pad_ctrl

//--- rtl/pao_port_override.sv
// pao_port_override: pad control override for the memory/pin-change port and the spi port
// assumes: control inputs are on clk; pad inputs are asynchronous and synchronised here
// Behaviour
// - first port pins carry bus bit n
// - memory interface owns first port pads
// - address in address phase, else write data
// - address phase flag marks address interval
// - pin-change enables force input enable on
// - pin input feeds read data and pin-change
// - spi clock on second port bit 7
// - slave forces clock pin to input
// - master clock direction follows register bit
// - master forces miso pin to input
// - slave miso direction follows register bit
// - slave forces mosi pin to input
// - master mosi direction follows register bit
// - forced spi inputs keep port pull-up control
// - override enable selects override value
// - global pull-up disable kills port pull-ups except on the first port while ext_mem_enable is set
`timescale 1ns/100ps
module pao_port_override (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // globals
  input wire logic global_pullup_disable,
  input wire logic sleep_active,
  // first port registers
  input wire logic [7:0] first_port_dir_bits,
  input wire logic [7:0] first_port_output_bit,
  // memory interface
  input wire logic ext_mem_enable,
  input wire logic address_phase_active,
  input wire logic mem_write,
  input wire logic [7:0] mem_addr_low,
  input wire logic [7:0] mem_write_data,
  output logic [7:0] mem_read_data,
  // pin change
  input wire logic pin_change_group_enable,
  input wire logic [7:0] pin_change_enable_n,
  output logic [7:0] pin_change_input,
  // second port registers
  input wire logic [7:0] second_port_dir_bits,
  input wire logic [7:0] second_port_output_bits,
  // spi
  input wire logic spi_enable,
  input wire logic spi_master,
  input wire logic spi_clock_out,
  input wire logic spi_slave_data_out,
  input wire logic spi_master_data_out,
  output logic spi_clock_in,
  output logic spi_master_data_in,
  output logic spi_slave_data_in,
  // first port pads
  input wire logic [7:0] first_pad_in,
  output logic [7:0] first_pad_pullup,
  output logic [7:0] first_pad_oe,
  output logic [7:0] first_pad_out,
  output logic [7:0] first_pad_in_en,
  // second port pads
  input wire logic [7:0] second_pad_in,
  output logic [7:0] second_pad_pullup,
  output logic [7:0] second_pad_oe,
  output logic [7:0] second_pad_out,
  output logic [7:0] second_pad_in_en
);
  import pao_pkg::*;

  logic drive_phase;
  logic spi_as_master;
  logic spi_as_slave;
  // first port override pairs, one bit per pin
  logic [7:0] a_pullup_override_enable;
  logic [7:0] a_pullup_override_value;
  logic [7:0] a_direction_override_enable;
  logic [7:0] a_direction_override_value;
  logic [7:0] a_value_override_enable;
  logic [7:0] a_value_override_value;
  logic [7:0] a_input_enable_override_enable;
  logic [7:0] a_input_enable_override_value;
  // second port override pairs; only the three spi bits are ever set
  logic [7:0] b_pullup_override_enable;
  logic [7:0] b_pullup_override_value;
  logic [7:0] b_direction_override_enable;
  logic [7:0] b_direction_override_value;
  logic [7:0] b_value_override_enable;
  logic [7:0] b_value_override_value;
  logic [7:0] b_input_enable_override_enable;
  logic [7:0] b_input_enable_override_value;
  // resolved pad controls ahead of the output flops
  logic [7:0] a_pu;
  logic [7:0] a_dir;
  logic [7:0] a_val;
  logic [7:0] a_ie;
  logic [7:0] b_pu;
  logic [7:0] b_dir;
  logic [7:0] b_val;
  logic [7:0] b_ie;
  // pad levels after the two-flop synchronisers
  logic [7:0] first_din;
  logic [7:0] second_din;
  // registered pad controls, one flop set per concern
  logic [7:0] a_pu_reg;
  logic [7:0] a_dir_reg;
  logic [7:0] a_val_reg;
  logic [7:0] a_ie_reg;
  logic [7:0] b_pu_reg;
  logic [7:0] b_dir_reg;
  logic [7:0] b_val_reg;
  logic [7:0] b_ie_reg;

  // memory bus drives the pins in address phase or write
  assign drive_phase = mem_write | address_phase_active;

  // first port overrides, pin n is bus bit n
  assign a_pullup_override_enable = {PAO_PORT_W{ext_mem_enable}};
  assign a_pullup_override_value = {PAO_PORT_W{~drive_phase}} & first_port_output_bit;
  assign a_direction_override_enable = {PAO_PORT_W{ext_mem_enable}};
  assign a_direction_override_value = {PAO_PORT_W{drive_phase}};
  assign a_value_override_enable = {PAO_PORT_W{ext_mem_enable}};
  assign a_value_override_value = address_phase_active ? mem_addr_low
                : (mem_write_data & {PAO_PORT_W{mem_write}});
  assign a_input_enable_override_enable = {PAO_PORT_W{pin_change_group_enable}} & pin_change_enable_n;
  assign a_input_enable_override_value = 8'hff;

  // spi roles
  assign spi_as_master = spi_enable & spi_master;
  assign spi_as_slave = spi_enable & ~spi_master;

  // second port overrides: slave forces clock and mosi in, master forces miso in
  always_comb begin
    b_pullup_override_enable = 8'h00;
    b_pullup_override_value = 8'h00;
    b_direction_override_enable = 8'h00;
    b_direction_override_value = 8'h00;
    b_value_override_enable = 8'h00;
    b_value_override_value = 8'h00;
    b_input_enable_override_enable = 8'h00;
    b_input_enable_override_value = 8'h00;
    b_pullup_override_enable[PAO_SCK_BIT] = spi_as_slave;
    b_direction_override_enable[PAO_SCK_BIT] = spi_as_slave;
    b_value_override_enable[PAO_SCK_BIT] = spi_as_master;
    b_value_override_value[PAO_SCK_BIT] = spi_clock_out;
    b_pullup_override_enable[PAO_MISO_BIT] = spi_as_master;
    b_direction_override_enable[PAO_MISO_BIT] = spi_as_master;
    b_value_override_enable[PAO_MISO_BIT] = spi_as_slave;
    b_value_override_value[PAO_MISO_BIT] = spi_slave_data_out;
    b_pullup_override_enable[PAO_MOSI_BIT] = spi_as_slave;
    b_direction_override_enable[PAO_MOSI_BIT] = spi_as_slave;
    b_value_override_enable[PAO_MOSI_BIT] = spi_as_master;
    b_value_override_value[PAO_MOSI_BIT] = spi_master_data_out;
    // forced inputs keep the port bit pull-up, still gated by global disable
    b_pullup_override_value[PAO_SCK_BIT] = second_port_output_bits[PAO_SCK_BIT] & ~global_pullup_disable;
    b_pullup_override_value[PAO_MISO_BIT] = second_port_output_bits[PAO_MISO_BIT] & ~global_pullup_disable;
    b_pullup_override_value[PAO_MOSI_BIT] = second_port_output_bits[PAO_MOSI_BIT] & ~global_pullup_disable;
  end

  // first port resolution
  pao_pad_ctrl u_first (
    .dir_bits(first_port_dir_bits),
    .port_bits(first_port_output_bit),
    .global_pullup_disable(global_pullup_disable),
    .sleep_active(sleep_active),
    .pullup_override_enable(a_pullup_override_enable),
    .pullup_override_value(a_pullup_override_value),
    .direction_override_enable(a_direction_override_enable),
    .direction_override_value(a_direction_override_value),
    .value_override_enable(a_value_override_enable),
    .value_override_value(a_value_override_value),
    .input_enable_override_enable(a_input_enable_override_enable),
    .input_enable_override_value(a_input_enable_override_value),
    .pull_en(a_pu),
    .dir(a_dir),
    .value(a_val),
    .in_en(a_ie)
  );

  // second port resolution
  pao_pad_ctrl u_second (
    .dir_bits(second_port_dir_bits),
    .port_bits(second_port_output_bits),
    .global_pullup_disable(global_pullup_disable),
    .sleep_active(sleep_active),
    .pullup_override_enable(b_pullup_override_enable),
    .pullup_override_value(b_pullup_override_value),
    .direction_override_enable(b_direction_override_enable),
    .direction_override_value(b_direction_override_value),
    .value_override_enable(b_value_override_enable),
    .value_override_value(b_value_override_value),
    .input_enable_override_enable(b_input_enable_override_enable),
    .input_enable_override_value(b_input_enable_override_value),
    .pull_en(b_pu),
    .dir(b_dir),
    .value(b_val),
    .in_en(b_ie)
  );

  // pad controls are registered so every pad control output comes from a flop;
  // this costs one cycle of latency but keeps mux glitches off the pads
  // first port pull-up enables; reset leaves every pull-up off
  always_ff @(posedge clk) begin
    if (rst) begin
      a_pu_reg <= PAO_RST_PULLUP;
    end else begin
      a_pu_reg <= a_pu;
    end
  end

  // first port output enables; reset keeps every pin an input
  always_ff @(posedge clk) begin
    if (rst) begin
      a_dir_reg <= PAO_RST_DIR;
    end else begin
      a_dir_reg <= a_dir;
    end
  end

  // first port output values
  always_ff @(posedge clk) begin
    if (rst) begin
      a_val_reg <= PAO_RST_VALUE;
    end else begin
      a_val_reg <= a_val;
    end
  end

  // first port input enables; open in reset, but pins read back two cycles after reset through the synchronisers
  always_ff @(posedge clk) begin
    if (rst) begin
      a_ie_reg <= PAO_RST_INEN;
    end else begin
      a_ie_reg <= a_ie;
    end
  end

  // second port pull-up enables
  always_ff @(posedge clk) begin
    if (rst) begin
      b_pu_reg <= PAO_RST_PULLUP;
    end else begin
      b_pu_reg <= b_pu;
    end
  end

  // second port output enables
  always_ff @(posedge clk) begin
    if (rst) begin
      b_dir_reg <= PAO_RST_DIR;
    end else begin
      b_dir_reg <= b_dir;
    end
  end

  // second port output values
  always_ff @(posedge clk) begin
    if (rst) begin
      b_val_reg <= PAO_RST_VALUE;
    end else begin
      b_val_reg <= b_val;
    end
  end

  // second port input enables
  always_ff @(posedge clk) begin
    if (rst) begin
      b_ie_reg <= PAO_RST_INEN;
    end else begin
      b_ie_reg <= b_ie;
    end
  end

  assign first_pad_pullup = a_pu_reg;
  assign first_pad_oe = a_dir_reg;
  assign first_pad_out = a_val_reg;
  assign first_pad_in_en = a_ie_reg;
  assign second_pad_pullup = b_pu_reg;
  assign second_pad_oe = b_dir_reg;
  assign second_pad_out = b_val_reg;
  assign second_pad_in_en = b_ie_reg;

  // pad inputs synchronised before any use
  pao_sync2 u_sync_first (
    .clk(clk),
    .rst(rst),
    .d(first_pad_in),
    .q(first_din)
  );

  pao_sync2 u_sync_second (
    .clk(clk),
    .rst(rst),
    .d(second_pad_in),
    .q(second_din)
  );

  // digital input, clamped when input enable is off, feeds both consumers
  assign mem_read_data = first_din & a_ie_reg;
  assign pin_change_input = first_din & a_ie_reg;
  assign spi_clock_in = second_din[PAO_SCK_BIT] & b_ie_reg[PAO_SCK_BIT];
  assign spi_master_data_in = second_din[PAO_MISO_BIT] & b_ie_reg[PAO_MISO_BIT];
  assign spi_slave_data_in = second_din[PAO_MOSI_BIT] & b_ie_reg[PAO_MOSI_BIT];
endmodule // pao_port_override

//--- rtl/pao_sync2.sv
// pao_sync2: two-flop synchroniser for a bus of pin levels
// assumes: single clock, synchronous active-high reset
`timescale 1ns/100ps
module pao_sync2 (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // data
  input wire logic [7:0] d,
  output logic [7:0] q
);
  import pao_pkg::*;
  logic [7:0] meta_reg;
  logic [7:0] q_reg;

  // first stage read only by second stage
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_reg <= PAO_RST_DIN;
      q_reg <= PAO_RST_DIN;
    end else begin
      meta_reg <= d;
      q_reg <= meta_reg;
    end
  end
  assign q = q_reg;
endmodule // pao_sync2

//--- verification/pao_pad_peer.sv
// pao_pad_peer: far side of one 8-bit port (memory chip or spi peer)
// assumes: pad controls come from the block; peer drives only undriven pins
`timescale 1ns/100ps
module pao_pad_peer (
  // clock
  input wire logic clk,
  // block pad controls
  input wire logic [7:0] oe,
  input wire logic [7:0] out,
  input wire logic [7:0] pu,
  // peer drive
  input wire logic drv,
  input wire logic [7:0] dat,
  // resolved pin levels
  output logic [7:0] pin
);
  logic float_reg = 1'b0;
  // released lines without pull-up wander each cycle so stale values never pass
  always_ff @(posedge clk) float_reg <= !float_reg;
  // wire level: block, then peer, then pull-up or floating
  always_comb for (int i = 0; i < 8; i++) pin[i] = oe[i] ? out[i] : drv ? dat[i] : (pu[i] | float_reg);
endmodule // pao_pad_peer

//--- verification/pao_port_override_props.sv
// pao_port_override_props: concurrent checks on the pad override outputs
// assumes: bound to pao_port_override, one clock, sync active-high reset
`timescale 1ns/100ps
module pao_port_override_props (
  // clock, reset and controls
  input wire logic clk, rst, global_pullup_disable, sleep_active, ext_mem_enable, address_phase_active, mem_write,
  input wire logic pin_change_group_enable, spi_enable, spi_master, spi_clock_out,
  input wire logic [7:0] first_port_dir_bits, first_port_output_bit, mem_addr_low, mem_write_data, pin_change_enable_n,
  input wire logic [7:0] second_port_dir_bits, second_port_output_bits, first_pad_in,
  // observed outputs
  input wire logic [7:0] mem_read_data, pin_change_input, first_pad_pullup, first_pad_oe, first_pad_out, first_pad_in_en,
  input wire logic [7:0] second_pad_pullup, second_pad_oe, second_pad_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // memory bus phases
  a_mem_addr_drive: assert property (ext_mem_enable && address_phase_active |=> first_pad_oe == 8'hff &&
    first_pad_out == $past(mem_addr_low) && first_pad_pullup == 8'h00) else $error("address phase drive wrong");
  a_mem_write_drive: assert property (ext_mem_enable && !address_phase_active && mem_write |=>
    first_pad_oe == 8'hff && first_pad_out == $past(mem_write_data)) else $error("write data drive wrong");
  a_mem_idle_input: assert property (ext_mem_enable && !address_phase_active && !mem_write |=>
    first_pad_oe == 8'h00 && first_pad_pullup == $past(first_port_output_bit)) else $error("idle bus pads wrong");
  // plain port and input enables
  a_plain_port_ctrl: assert property (!ext_mem_enable |=> first_pad_oe == $past(first_port_dir_bits) &&
    first_pad_pullup == (~$past(first_port_dir_bits) & $past(first_port_output_bit) &
    {8{!$past(global_pullup_disable)}})) else $error("plain port controls wrong");
  a_pin_change_force: assert property (pin_change_group_enable |=>
    (first_pad_in_en & $past(pin_change_enable_n)) == $past(pin_change_enable_n)) else $error("input not forced on");
  a_sleep_clamp_off: assert property (sleep_active && !pin_change_group_enable |=> first_pad_in_en == 8'h00)
    else $error("sleep clamp missing");
  a_read_fanout_tie: assert property (!$past(rst) && !$past(rst, 2) |-> mem_read_data == pin_change_input &&
    mem_read_data == ($past(first_pad_in, 2) & first_pad_in_en)) else $error("read fan-out mismatch");
  // spi pin ownership
  a_spi_slave_pins: assert property (spi_enable && !spi_master |=> (second_pad_oe & 8'ha0) == 8'h00 &&
    second_pad_oe[6] == $past(second_port_dir_bits[6])) else $error("slave pin directions wrong");
  a_spi_master_pins: assert property (spi_enable && spi_master |=> !second_pad_oe[6] &&
    second_pad_oe[7] == $past(second_port_dir_bits[7]) && second_pad_oe[5] == $past(second_port_dir_bits[5]) &&
    second_pad_out[7] == $past(spi_clock_out)) else $error("master pin controls wrong");
  a_spi_forced_pullup: assert property (spi_enable && !spi_master |=> second_pad_pullup[7] ==
    ($past(second_port_output_bits[7]) && !$past(global_pullup_disable))) else $error("forced pull-up wrong");
  // main scenarios reached
  c_addr_phase: cover property (ext_mem_enable && address_phase_active);
  c_spi_slave: cover property (spi_enable && !spi_master);
  c_sleep_wake: cover property (sleep_active && pin_change_group_enable);
endmodule // pao_port_override_props
bind pao_port_override pao_port_override_props props_u (.clk, .rst, .global_pullup_disable, .sleep_active,
  .ext_mem_enable, .address_phase_active, .mem_write, .pin_change_group_enable, .spi_enable, .spi_master,
  .spi_clock_out, .first_port_dir_bits, .first_port_output_bit, .mem_addr_low, .mem_write_data,
  .pin_change_enable_n, .second_port_dir_bits, .second_port_output_bits, .mem_read_data, .pin_change_input,
  .first_pad_pullup, .first_pad_oe, .first_pad_out, .first_pad_in_en, .second_pad_pullup, .second_pad_oe,
  .second_pad_out, .first_pad_in);

//--- verification/testbench.sv
// testbench: directed sequences on the port override block
// assumes: inputs change 1 ns after the rising edge; outputs registered one cycle
`timescale 1ns/100ps
module testbench;
  import pao_pkg::*;
  // design inputs
  logic clk = 1'b0, rst = 1'b1, global_pullup_disable = 1'b0, sleep_active = 1'b0, ext_mem_enable = 1'b0;
  logic address_phase_active = 1'b0, mem_write = 1'b0, pin_change_group_enable = 1'b0, spi_enable = 1'b0;
  logic spi_master = 1'b0, spi_clock_out = 1'b0, spi_slave_data_out = 1'b0, spi_master_data_out = 1'b0;
  logic [7:0] first_port_dir_bits = 8'h00, first_port_output_bit = 8'h00, mem_addr_low = 8'h00;
  logic [7:0] mem_write_data = 8'h00, pin_change_enable_n = 8'h00;
  logic [7:0] second_port_dir_bits = 8'h00, second_port_output_bits = 8'h00;
  // peer drive
  logic peer_drv = 1'b0;
  logic [7:0] peer_dat = 8'h00;
  // design outputs, peer pin levels and counters
  logic [7:0] mem_read_data, pin_change_input, first_pad_in, first_pad_pullup, first_pad_oe, first_pad_out;
  logic [7:0] first_pad_in_en, second_pad_in, second_pad_pullup, second_pad_oe, second_pad_out, second_pad_in_en;
  logic spi_clock_in, spi_master_data_in, spi_slave_data_in;
  int err_total = 0, checked = 0, cyc = 0;
  always #5 clk = ~clk;
  pao_port_override dut_u (.clk(clk), .rst(rst), .global_pullup_disable(global_pullup_disable),
    .sleep_active(sleep_active), .first_port_dir_bits(first_port_dir_bits),
    .first_port_output_bit(first_port_output_bit), .ext_mem_enable(ext_mem_enable),
    .address_phase_active(address_phase_active), .mem_write(mem_write), .mem_addr_low(mem_addr_low),
    .mem_write_data(mem_write_data), .mem_read_data(mem_read_data),
    .pin_change_group_enable(pin_change_group_enable), .pin_change_enable_n(pin_change_enable_n),
    .pin_change_input(pin_change_input), .second_port_dir_bits(second_port_dir_bits),
    .second_port_output_bits(second_port_output_bits), .spi_enable(spi_enable), .spi_master(spi_master),
    .spi_clock_out(spi_clock_out), .spi_slave_data_out(spi_slave_data_out),
    .spi_master_data_out(spi_master_data_out), .spi_clock_in(spi_clock_in),
    .spi_master_data_in(spi_master_data_in), .spi_slave_data_in(spi_slave_data_in),
    .first_pad_in(first_pad_in), .first_pad_pullup(first_pad_pullup), .first_pad_oe(first_pad_oe),
    .first_pad_out(first_pad_out), .first_pad_in_en(first_pad_in_en), .second_pad_in(second_pad_in),
    .second_pad_pullup(second_pad_pullup), .second_pad_oe(second_pad_oe), .second_pad_out(second_pad_out),
    .second_pad_in_en(second_pad_in_en));
  // far side of both ports
  pao_pad_peer mem_peer_u (.clk(clk), .oe(first_pad_oe), .out(first_pad_out), .pu(first_pad_pullup),
    .drv(peer_drv), .dat(peer_dat), .pin(first_pad_in));
  pao_pad_peer spi_peer_u (.clk(clk), .oe(second_pad_oe), .out(second_pad_out), .pu(second_pad_pullup),
    .drv(peer_drv), .dat(peer_dat), .pin(second_pad_in));
  // compare one byte
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // let n edges pass, then settle
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // report and stop
  task automatic test_done;
    $display("checked=%0d err_total=%0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // cycle ceiling
  always @(posedge clk) begin
    cyc++;
    if (cyc == 400) begin
      err_total++;
      test_done;
    end
  end
  // main sequence
  initial begin
    step(12);
    chk(first_pad_in_en, PAO_RST_INEN);
    chk(first_pad_oe | first_pad_pullup, 8'h00);
    rst = 1'b0;
    first_port_dir_bits = 8'h0f;
    first_port_output_bit = 8'h3c;
    step(1);
    chk(first_pad_oe, 8'h0f);
    chk(first_pad_pullup, 8'h30);
    global_pullup_disable = 1'b1;
    step(1);
    chk(first_pad_pullup, 8'h00);
    global_pullup_disable = 1'b0;
    ext_mem_enable = 1'b1;
    address_phase_active = 1'b1;
    mem_addr_low = 8'ha5;
    mem_write_data = 8'h5a;
    step(1);
    chk(first_pad_oe, 8'hff);
    chk(first_pad_out, 8'ha5);
    chk(first_pad_pullup, 8'h00);
    address_phase_active = 1'b0;
    mem_write = 1'b1;
    step(1);
    chk(first_pad_out, 8'h5a);
    mem_write = 1'b0;
    peer_drv = 1'b1;
    peer_dat = 8'h96;
    step(3);
    chk(first_pad_oe | first_pad_out, 8'h00);
    chk(first_pad_pullup, 8'h3c);
    chk(mem_read_data, 8'h96);
    chk(pin_change_input, 8'h96);
    ext_mem_enable = 1'b0;
    first_port_dir_bits = 8'h00;
    sleep_active = 1'b1;
    pin_change_group_enable = 1'b1;
    pin_change_enable_n = 8'h81;
    peer_dat = 8'hff;
    step(3);
    chk(first_pad_in_en, 8'h81);
    chk(pin_change_input, 8'h81);
    pin_change_group_enable = 1'b0;
    step(3);
    chk(first_pad_in_en | pin_change_input, 8'h00);
    sleep_active = 1'b0;
    spi_enable = 1'b1;
    second_port_dir_bits = 8'hff;
    second_port_output_bits = 8'hff;
    // slave pass then master pass
    for (int m = 0; m < 2; m++) begin
      spi_master = m[0];
      peer_dat = m ? 8'h40 : 8'ha0;
      step(3);
      chk(second_pad_oe & 8'he0, m ? 8'ha0 : 8'h40);
      chk(second_pad_pullup & 8'he0, m ? 8'h40 : 8'ha0);
      chk(second_pad_out & 8'he0, m ? 8'h40 : 8'ha0);
      chk({spi_clock_in, spi_master_data_in, spi_slave_data_in, 5'h00}, m ? 8'h40 : 8'ha0);
      chk(second_pad_in_en, 8'hff);
    end
    second_port_dir_bits = 8'h00;
    step(1);
    chk(second_pad_oe & 8'he0, 8'h00);
    test_done;
  end
endmodule // testbench
